/* File: tb/prog_mem_model.sv */
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [data_move_pkg::INSTR_W-1:0] o_instr
);
  // ----------------------------------------
  // Instruction word source
  // ----------------------------------------
  initial begin
    o_valid = 1'b0;
    o_instr = 16'h0000;
  end

  // Holds the word until an edge that sees ready high
  task automatic issue(input logic [15:0] word, input int gap);
    logic rdy;
    // After a release, one edge passes before valid rises again
    if (o_valid !== 1'b1) begin
      @(posedge i_clk);
      #1;
    end
    if (gap > 0) begin
      o_valid = 1'b0;
      o_instr = ~o_instr;
      repeat (gap) begin
        @(posedge i_clk);
        #1;
      end
    end
    o_valid = 1'b1;
    o_instr = word;
    do begin
      rdy = i_ready;
      @(posedge i_clk);
      #1;
    end while (rdy !== 1'b1);
  endtask : issue

  // Released word lines do not keep the last value
  task automatic idle();
    o_valid = 1'b0;
    o_instr = ~o_instr;
  endtask : idle
endmodule : prog_mem_model

/* File: tb/tb_data_move_instruction_exec.sv */
`timescale 1ns/1ps
module tb_data_move_instruction_exec;
  import data_move_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_instr_valid;
  logic [15:0] i_instr;
  logic i_carry_flag = 1'b0;
  logic i_lcd_we = 1'b0;
  logic [4:0] i_lcd_waddr = 5'h00;
  logic [3:0] i_lcd_wdata = 4'h0;
  logic i_hold_enter = 1'b0;
  logic i_hold_exit = 1'b0;
  logic i_div0_overflow = 1'b0;
  logic i_tmr0_underflow = 1'b0;
  logic i_wake_input_port_change = 1'b0;
  logic i_div1_overflow = 1'b0;
  logic i_tmr1_underflow = 1'b0;
  logic [6:0] i_peek_addr = 7'h00;
  logic o_ready;
  logic o_zero_flag;
  logic [3:0] o_acc;
  logic [3:0] o_page_register;
  logic [3:0] o_hold_release_causes_low;
  logic [3:0] o_hold_release_causes_high;
  logic [3:0] o_peek_data;
  int bad_count = 0;
  int n_compared = 0;
  logic [3:0] d;
  logic [3:0] exp_lo [5] = '{4'h1, 4'h3, 4'h7, 4'h7, 4'h7};
  logic [3:0] exp_hi [5] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h3};

  always #5 i_clk = ~i_clk;

  data_move_exec data_move_exec_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_carry_flag(i_carry_flag),
    .i_lcd_we(i_lcd_we), .i_lcd_waddr(i_lcd_waddr), .i_lcd_wdata(i_lcd_wdata),
    .i_hold_enter(i_hold_enter), .i_hold_exit(i_hold_exit),
    .i_div0_overflow(i_div0_overflow), .i_tmr0_underflow(i_tmr0_underflow),
    .i_wake_input_port_change(i_wake_input_port_change),
    .i_div1_overflow(i_div1_overflow), .i_tmr1_underflow(i_tmr1_underflow),
    .i_peek_addr(i_peek_addr), .o_ready(o_ready), .o_acc(o_acc),
    .o_zero_flag(o_zero_flag), .o_page_register(o_page_register),
    .o_hold_release_causes_low(o_hold_release_causes_low),
    .o_hold_release_causes_high(o_hold_release_causes_high), .o_peek_data(o_peek_data));

  prog_mem_model prog_mem_model_inst (.i_clk(i_clk), .i_ready(o_ready),
    .o_valid(i_instr_valid), .o_instr(i_instr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_nib(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_nib

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick

  task automatic run(input logic [15:0] w);
    prog_mem_model_inst.issue(w, 0);
    prog_mem_model_inst.idle();
  endtask : run

  task automatic peek(input logic [6:0] a, output logic [3:0] v);
    i_peek_addr = a;
    tick();
    v = o_peek_data;
  endtask : peek

  task automatic lcd_wr(input logic [4:0] a, input logic [3:0] v);
    i_lcd_we = 1'b1;
    i_lcd_waddr = a;
    i_lcd_wdata = v;
    tick();
    i_lcd_we = 1'b0;
    tick();
  endtask : lcd_wr

  task automatic hold_exit(input logic [4:0] c);
    {i_tmr1_underflow, i_div1_overflow, i_wake_input_port_change,
     i_tmr0_underflow, i_div0_overflow} = c;
    i_hold_exit = 1'b1;
    tick();
    i_hold_exit = 1'b0;
    {i_tmr1_underflow, i_div1_overflow, i_wake_input_port_change,
     i_tmr0_underflow, i_div0_overflow} = 5'h00;
    tick();
  endtask : hold_exit

  task automatic hold_enter();
    i_hold_enter = 1'b1;
    tick();
    i_hold_enter = 1'b0;
  endtask : hold_enter

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_bit(o_ready, 1'b1);
    chk_nib(o_acc, 4'h0);
    chk_bit(o_zero_flag, 1'b0);
    chk_nib(o_page_register, 4'h0);
    chk_nib(o_hold_release_causes_low, 4'h0);
    chk_nib(o_hold_release_causes_high, 4'h0);
    chk_nib(o_peek_data, 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_mid_reset();
    hold_exit(5'h1f);
    chk_nib(o_hold_release_causes_high, 4'h3);
    i_nrst = 1'b0;
    tick();
    i_nrst = 1'b1;
    t_reset();
    peek(7'h60, d); chk_nib(d, 4'h0);
    $display("test mid_reset done");
  endtask : t_mid_reset

  task automatic t_lcd_load();
    lcd_wr(5'h05, 4'ha);
    lcd_wr(5'h1f, 4'h5);
    lcd_wr(5'h01, 4'h2);
    lcd_wr(5'h02, 4'h7);
    prog_mem_model_inst.issue({7'h23, 5'h05, 4'h3}, 0);
    prog_mem_model_inst.issue({7'h23, 5'h1f, 4'hf}, 0);
    prog_mem_model_inst.issue({7'h23, 5'h01, 4'h1}, 0);
    run({7'h23, 5'h02, 4'h2});
    peek(7'h03, d); chk_nib(d, 4'ha);
    peek(7'h0f, d); chk_nib(d, 4'h5);
    peek(7'h02, d); chk_nib(d, 4'h7);
    $display("test lcd_load done");
  endtask : t_lcd_load

  task automatic t_direct();
    prog_mem_model_inst.issue({5'h1d, 4'h4, 7'h03}, 0);
    run({5'h1d, 4'h5, 7'h0f});
    peek(7'h04, d); chk_nib(d, 4'ha);
    peek(7'h05, d); chk_nib(d, 4'h5);
    $display("test direct done");
  endtask : t_direct

  task automatic t_indirect();
    run({9'h0bd, 7'h01});
    chk_nib(o_page_register, 4'h2);
    run({5'h1b, 4'h3, 7'h02});
    chk_bit(o_ready, 1'b0);
    tick();
    chk_bit(o_ready, 1'b1);
    peek(7'h27, d); chk_nib(d, 4'ha);
    run({9'h0bd, 7'h05});
    chk_nib(o_page_register, 4'h5);
    run({9'h0bd, 7'h03});
    chk_nib(o_page_register, 4'ha);
    run({5'h19, 4'h6, 7'h02});
    chk_bit(o_ready, 1'b0);
    peek(7'h06, d); chk_nib(d, 4'ha);
    $display("test indirect done");
  endtask : t_indirect

  task automatic t_carry();
    i_carry_flag = 1'b1;
    run({9'h0b2, 7'h03});
    chk_nib(o_acc, 4'h1);
    chk_bit(o_zero_flag, 1'b0);
    i_carry_flag = 1'b0;
    run({9'h0b2, 7'h27});
    chk_nib(o_acc, 4'h0);
    chk_bit(o_zero_flag, 1'b1);
    peek(7'h03, d); chk_nib(d, 4'h1);
    peek(7'h27, d); chk_nib(d, 4'h0);
    $display("test carry done");
  endtask : t_carry

  task automatic t_causes();
    hold_enter();
    i_div0_overflow = 1'b1;
    tick();
    i_div0_overflow = 1'b0;
    chk_nib(o_hold_release_causes_low, 4'h0);
    for (int i = 0; i < 5; i++) begin
      hold_exit(5'h01 << i);
      chk_nib(o_hold_release_causes_low, exp_lo[i]);
      chk_nib(o_hold_release_causes_high, exp_hi[i]);
    end
    run({9'h093, 7'h60});
    chk_nib(o_acc, 4'h3);
    chk_bit(o_zero_flag, 1'b0);
    run({9'h092, 7'h61});
    chk_nib(o_acc, 4'h7);
    peek(7'h60, d); chk_nib(d, 4'h3);
    peek(7'h61, d); chk_nib(d, 4'h7);
    hold_enter();
    run({9'h092, 7'h62});
    chk_nib(o_acc, 4'h0);
    chk_bit(o_zero_flag, 1'b1);
    $display("test causes done");
  endtask : t_causes

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    t_reset();
    t_lcd_load();
    t_direct();
    t_indirect();
    t_carry();
    t_causes();
    t_mid_reset();
    end_sim();
  end
endmodule : tb_data_move_instruction_exec

/* File: verilog/data_move_exec.sv */
// Notes on behaviour
// RQ1: LCD-load opcode copies addressed LCD RAM word into working register, one cycle.
// RQ2: Direct-load opcode copies memory word at 7-bit address into working register.
// RQ3: Indirect load uses page bits times 16 plus pointer word; two cycles.
// RQ4: Indirect store writes working register to the same page-indirect address; two cycles.
// RQ5: Page-load opcode loads page register from direct memory word in one cycle.
// RQ6: Carry copy puts carry in bit 0 of accumulator and memory, rest zero.
// RQ7: High cause copy moves upper cause flags to accumulator and memory, sets zero.
// RQ8: High cause bit 0 set when hold exits on divider 1 overflow.
// RQ9: High cause bit 1 set when hold exits on timer 1 underflow.
// RQ10: Low cause copy moves lower cause flags to accumulator and memory, sets zero.
// RQ11: Low cause bit 0 set when hold exits on divider 0 overflow.
// RQ12: Low cause bit 1 set when hold exits on timer 0 underflow.
// RQ13: Low cause bit 2 set when hold exits on wake input port change.
// RQ14: Reserved cause bits read zero so the zero flag sees defined flags only.
// RQ15: Zero flag set when the copied accumulator value is zero, else cleared.
`timescale 1ns/1ps
module data_move_exec #(
  parameter int MEM_DEPTH = 128,
  parameter int LCD_DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_instr_valid,
  input wire logic [data_move_pkg::INSTR_W-1:0] i_instr,
  input wire logic i_carry_flag,
  input wire logic i_lcd_we,
  input wire logic [data_move_pkg::LCD_ADDR_W-1:0] i_lcd_waddr,
  input wire logic [data_move_pkg::NIBBLE_W-1:0] i_lcd_wdata,
  input wire logic i_hold_enter,
  input wire logic i_hold_exit,
  input wire logic i_div0_overflow,
  input wire logic i_tmr0_underflow,
  input wire logic i_wake_input_port_change,
  input wire logic i_div1_overflow,
  input wire logic i_tmr1_underflow,
  input wire logic [data_move_pkg::MEM_ADDR_W-1:0] i_peek_addr,
  output logic o_ready,
  output logic [data_move_pkg::NIBBLE_W-1:0] o_acc,
  output logic o_zero_flag,
  output logic [data_move_pkg::NIBBLE_W-1:0] o_page_register,
  output logic [data_move_pkg::NIBBLE_W-1:0] o_hold_release_causes_low,
  output logic [data_move_pkg::NIBBLE_W-1:0] o_hold_release_causes_high,
  output logic [data_move_pkg::NIBBLE_W-1:0] o_peek_data
);
  import data_move_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [MEM_ADDR_W-1:0] page_addr(input logic [3:0] page,
                                                      input logic [3:0] ptr);
    page_addr = {page[PAGE_BITS-1:0], ptr};
  endfunction : page_addr

  function automatic logic is_zero(input logic [3:0] value);
    is_zero = (value == NIBBLE_RST);
  endfunction : is_zero

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NIBBLE_W-1:0] mem [MEM_DEPTH];
  logic [NIBBLE_W-1:0] next_mem [MEM_DEPTH];
  logic [NIBBLE_W-1:0] lcd_ram_word [LCD_DEPTH];
  logic [NIBBLE_W-1:0] next_lcd_ram_word [LCD_DEPTH];
  seq_state_e state;
  seq_state_e next_state;
  logic [NIBBLE_W-1:0] acc;
  logic [NIBBLE_W-1:0] next_acc;
  logic zero_flag;
  logic next_zero_flag;
  logic [NIBBLE_W-1:0] page_register;
  logic [NIBBLE_W-1:0] next_page_register;
  logic ind_store;
  logic next_ind_store;
  logic [WSEL_W-1:0] ind_wsel;
  logic [WSEL_W-1:0] next_ind_wsel;
  logic [MEM_ADDR_W-1:0] ind_addr;
  logic [MEM_ADDR_W-1:0] next_ind_addr;
  logic [NIBBLE_W-1:0] peek_data;
  logic [NIBBLE_W-1:0] low_q;
  logic [NIBBLE_W-1:0] high_q;
  logic [LOW_CAUSE_W-1:0] low_flags;
  logic [HIGH_CAUSE_W-1:0] high_flags;
  logic [LOW_CAUSE_W-1:0] low_set;
  logic [HIGH_CAUSE_W-1:0] high_set;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic take;
  logic is_lcd;
  logic is_dir;
  logic is_ldi;
  logic is_sti;
  logic is_page;
  logic is_carry;
  logic is_high;
  logic is_low;
  logic [MEM_ADDR_W-1:0] r_addr;
  logic [WSEL_W-1:0] w_long;
  logic [WSEL_W-1:0] w_short;
  logic [LCD_ADDR_W-1:0] lcd_addr;
  logic [NIBBLE_W-1:0] dir_word;
  logic [NIBBLE_W-1:0] lcd_word;
  logic [NIBBLE_W-1:0] ind_word;
  logic [NIBBLE_W-1:0] wr_word;
  logic [NIBBLE_W-1:0] low_word;
  logic [NIBBLE_W-1:0] high_word;

  assign take = i_instr_valid && (state == ST_FETCH);
  assign r_addr = i_instr[MEM_ADDR_W-1:0];
  assign w_long = i_instr[WSEL_LSB_LONG +: WSEL_W];
  assign w_short = i_instr[WSEL_W-1:0];
  assign lcd_addr = i_instr[LCD_ADDR_LSB +: LCD_ADDR_W];
  assign is_lcd = (i_instr[15:9] == OP_LCD_LOAD); // [RQ1]
  assign is_dir = (i_instr[15:11] == OP_DIR_LOAD); // [RQ2]
  assign is_ldi = (i_instr[15:11] == OP_IND_LOAD); // [RQ3]
  assign is_sti = (i_instr[15:11] == OP_IND_STORE); // [RQ4]
  assign is_page = (i_instr[15:7] == OP_PAGE_LOAD); // [RQ5]
  assign is_carry = (i_instr[15:7] == OP_CARRY_COPY); // [RQ6]
  assign is_high = (i_instr[15:7] == OP_HIGH_COPY); // [RQ7]
  assign is_low = (i_instr[15:7] == OP_LOW_COPY); // [RQ10]
  assign dir_word = mem[r_addr];
  assign lcd_word = lcd_ram_word[lcd_addr];
  assign ind_word = mem[ind_addr];
  assign wr_word = mem[ind_wsel];
  assign high_word = {2'b00, high_flags}; // [RQ14]
  assign low_word = {1'b0, low_flags}; // [RQ14]

  // ----------------------------------------------------------------
  // Hold release cause flags
  // ----------------------------------------------------------------
  assign high_set = {i_hold_exit && i_tmr1_underflow, // [RQ9]
                     i_hold_exit && i_div1_overflow}; // [RQ8]
  assign low_set = {i_hold_exit && i_wake_input_port_change, // [RQ13]
                    i_hold_exit && i_tmr0_underflow, // [RQ12]
                    i_hold_exit && i_div0_overflow}; // [RQ11]

  hold_cause_flags #(.WIDTH(HIGH_CAUSE_W)) u_high_flags (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_set(high_set),
    .i_clear(i_hold_enter),
    .o_flags(high_flags)
  );

  hold_cause_flags #(.WIDTH(LOW_CAUSE_W)) u_low_flags (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_set(low_set),
    .i_clear(i_hold_enter),
    .o_flags(low_flags)
  );

  // ----------------------------------------------------------------
  // Execution next state
  // ----------------------------------------------------------------
  always_comb begin
    next_mem = mem;
    next_lcd_ram_word = lcd_ram_word;
    next_state = state;
    next_acc = acc;
    next_zero_flag = zero_flag;
    next_page_register = page_register;
    next_ind_store = ind_store;
    next_ind_wsel = ind_wsel;
    next_ind_addr = ind_addr;
    if (i_lcd_we) begin
      next_lcd_ram_word[i_lcd_waddr] = i_lcd_wdata;
    end
    case (state)
      ST_FETCH: begin
        if (take) begin
          if (is_lcd) begin
            next_mem[w_short] = lcd_word; // [RQ1]
          end else if (is_dir) begin
            next_mem[w_long] = dir_word; // [RQ2]
          end else if (is_ldi || is_sti) begin
            next_ind_addr = page_addr(page_register, dir_word); // [RQ3] [RQ4]
            next_ind_wsel = w_long;
            next_ind_store = is_sti;
            next_state = ST_INDIRECT;
          end else if (is_page) begin
            next_page_register = dir_word; // [RQ5]
          end else if (is_carry) begin
            next_acc = {3'b000, i_carry_flag}; // [RQ6]
            next_mem[r_addr] = {3'b000, i_carry_flag};
            next_zero_flag = !i_carry_flag; // [RQ15]
          end else if (is_high) begin
            next_acc = high_word; // [RQ7]
            next_mem[r_addr] = high_word;
            next_zero_flag = is_zero(high_word); // [RQ15]
          end else if (is_low) begin
            next_acc = low_word; // [RQ10]
            next_mem[r_addr] = low_word;
            next_zero_flag = is_zero(low_word); // [RQ15]
          end
        end
      end
      ST_INDIRECT: begin
        if (ind_store) begin
          next_mem[ind_addr] = wr_word; // [RQ4]
        end else begin
          next_mem[ind_wsel] = ind_word; // [RQ3]
        end
        next_state = ST_FETCH;
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= NIBBLE_RST;
      end
      for (int j = 0; j < LCD_DEPTH; j++) begin
        lcd_ram_word[j] <= NIBBLE_RST;
      end
      state <= ST_FETCH;
      acc <= NIBBLE_RST;
      zero_flag <= 1'b0;
      page_register <= PAGE_RST;
      ind_store <= 1'b0;
      ind_wsel <= '0;
      ind_addr <= ADDR_RST;
      peek_data <= NIBBLE_RST;
      low_q <= NIBBLE_RST;
      high_q <= NIBBLE_RST;
    end else begin
      mem <= next_mem;
      lcd_ram_word <= next_lcd_ram_word;
      state <= next_state;
      acc <= next_acc;
      zero_flag <= next_zero_flag;
      page_register <= next_page_register;
      ind_store <= next_ind_store;
      ind_wsel <= next_ind_wsel;
      ind_addr <= next_ind_addr;
      peek_data <= next_mem[i_peek_addr];
      low_q <= {1'b0, low_flags | low_set};
      high_q <= {2'b00, high_flags | high_set};
    end
  end

  assign o_ready = state[0]; // One-hot fetch bit
  assign o_acc = acc;
  assign o_zero_flag = zero_flag;
  assign o_page_register = page_register;
  assign o_hold_release_causes_low = low_q;
  assign o_hold_release_causes_high = high_q;
  assign o_peek_data = peek_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence ind_start_s;
    take && (is_ldi || is_sti);
  endsequence

  sequence ind_second_s;
    (state == ST_INDIRECT) ##1 (state == ST_FETCH);
  endsequence

  lcd_load_a: assert property ((take && is_lcd && !(i_lcd_we)) |=>
    mem[$past(w_short)] == $past(lcd_word)) // [RQ1]
    else $error("lcd word not loaded");

  direct_load_a: assert property ((take && is_dir) |=>
    mem[$past(w_long)] == $past(dir_word)) // [RQ2]
    else $error("direct word not loaded");

  indirect_load_a: assert property ((take && is_ldi) ##1 (state == ST_INDIRECT) |=>
    mem[$past(ind_wsel)] == $past(ind_word)) // [RQ3]
    else $error("indirect load wrong");

  indirect_store_a: assert property ((take && is_sti) ##1 (state == ST_INDIRECT) |=>
    mem[$past(ind_addr)] == $past(wr_word)) // [RQ4]
    else $error("indirect store wrong");

  indirect_timing_a: assert property (ind_start_s |=> ind_second_s) // [RQ3] [RQ4]
    else $error("indirect not two cycles");

  page_load_a: assert property ((take && is_page) |=>
    page_register == $past(dir_word)) // [RQ5]
    else $error("page register not loaded");

  carry_copy_a: assert property ((take && is_carry) |=>
    (acc == {3'b000, $past(i_carry_flag)}) && (zero_flag == !$past(i_carry_flag))) // [RQ6]
    else $error("carry copy wrong");

  high_copy_a: assert property ((take && is_high) |=>
    (acc == $past(high_word)) && (acc[3:2] == 2'b00)) // [RQ7]
    else $error("high cause copy wrong");

  low_copy_a: assert property ((take && is_low) |=>
    (acc == $past(low_word)) && !acc[3]) // [RQ10]
    else $error("low cause copy wrong");

  div1_cause_a: assert property ((i_hold_exit && i_div1_overflow) |=>
    high_flags[0] ##1 o_hold_release_causes_high[0]) // [RQ8]
    else $error("divider 1 cause lost");

  tmr1_cause_a: assert property ((i_hold_exit && i_tmr1_underflow) |=>
    high_flags[1]) // [RQ9]
    else $error("timer 1 cause lost");

  div0_cause_a: assert property ((i_hold_exit && i_div0_overflow) |=>
    low_flags[0]) // [RQ11]
    else $error("divider 0 cause lost");

  tmr0_cause_a: assert property ((i_hold_exit && i_tmr0_underflow) |=>
    low_flags[1]) // [RQ12]
    else $error("timer 0 cause lost");

  wake_cause_a: assert property ((i_hold_exit && i_wake_input_port_change) |=>
    low_flags[2]) // [RQ13]
    else $error("wake port cause lost");

  reserved_zero_a: assert property (!o_hold_release_causes_low[3] &&
    (o_hold_release_causes_high[3:2] == 2'b00)) // [RQ14]
    else $error("reserved cause bit set");

  zero_flag_a: assert property ((take && (is_high || is_low || is_carry)) |=>
    zero_flag == (acc == 4'h0)) // [RQ15]
    else $error("zero flag mismatch");
endmodule : data_move_exec

/* File: verilog/data_move_pkg.sv */
package data_move_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 16;
  localparam int NIBBLE_W = 4;
  localparam int MEM_ADDR_W = 7;
  localparam int LCD_ADDR_W = 5;
  localparam int WSEL_W = 4;
  localparam int PAGE_BITS = 3;
  localparam int HIGH_CAUSE_W = 2;
  localparam int LOW_CAUSE_W = 3;
  // ----------------------------------------------------------------
  // Opcode prefixes and field positions
  // ----------------------------------------------------------------
  localparam logic [6:0] OP_LCD_LOAD = 7'h23;
  localparam logic [4:0] OP_DIR_LOAD = 5'h1D;
  localparam logic [4:0] OP_IND_LOAD = 5'h19;
  localparam logic [4:0] OP_IND_STORE = 5'h1B;
  localparam logic [8:0] OP_PAGE_LOAD = 9'h0BD;
  localparam logic [8:0] OP_CARRY_COPY = 9'h0B2;
  localparam logic [8:0] OP_HIGH_COPY = 9'h093;
  localparam logic [8:0] OP_LOW_COPY = 9'h092;
  localparam int LCD_ADDR_LSB = 4;
  localparam int WSEL_LSB_LONG = 7;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] NIBBLE_RST = 4'h0;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_INDIRECT = 2'b10
  } seq_state_e;
endpackage : data_move_pkg

/* File: verilog/hold_cause_flags.sv */
`timescale 1ns/1ps
module hold_cause_flags #(
  parameter int WIDTH = 3
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic i_clear,
  output logic [WIDTH-1:0] o_flags
);
  logic [WIDTH-1:0] flags;
  logic [WIDTH-1:0] next_flags;

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    next_flags = (i_clear ? '0 : flags) | i_set;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign o_flags = flags;
endmodule : hold_cause_flags
